/* File: rtl/fwsf_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - host polls erase status at an unprotected sector being erased.
// - poll bit may turn to data early; host re-reads for valid data.
// - host holds ce or oe high while changing bank address.
// - non-blank program locks algorithm; host must issue reset sequence.
// - host checks window bit before and after each extra sector erase; code reads it only at the first status read after the erase command.
module fwsf_ctrl #(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // avalon-mm slave
  input  wire logic [3:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // flash pins
  output logic [ADDR_W-1:0]      o_fl_addr,
  input  wire logic [7:0]        i_fl_dq,
  output logic [7:0]             o_fl_dq,
  output logic                   o_fl_dq_oe,
  output logic                   o_fl_ce_n,
  output logic                   o_fl_oe_n,
  output logic                   o_fl_we_n
);
  // ****************************************************************
  // pin synchroniser and strobe engine
  // ****************************************************************
  logic [7:0] dq_s1_r, dq_s2_r;
  logic       smp_d1_r, smp_d2_r;
  logic       st_start, st_write, st_sample, st_done;
  logic       ce_n_w, oe_n_w, we_n_w;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dq_s1_r  <= 8'h00;
      dq_s2_r  <= 8'h00;
      smp_d1_r <= 1'b0;
      smp_d2_r <= 1'b0;
    end else begin
      dq_s1_r  <= i_fl_dq;
      dq_s2_r  <= dq_s1_r;
      smp_d1_r <= st_sample;
      smp_d2_r <= smp_d1_r;
    end
  end

  fwsf_strobe #(
    .LOW_CYC  (fwsf_pkg::STROBE_CYC),
    .HIGH_CYC (fwsf_pkg::HIGH_CYC)
  ) u_strobe (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_start  (st_start),
    .i_write  (st_write),
    .o_ce_n   (ce_n_w),
    .o_oe_n   (oe_n_w),
    .o_we_n   (we_n_w),
    .o_sample (st_sample),
    .o_done   (st_done)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CMD   = 3'b001,
    S_RD1   = 3'b010,
    S_RD2   = 3'b011,
    S_CHECK = 3'b100,
    S_RST   = 3'b101
  } fwsf_state_t;

  fwsf_state_t     state_r, state_nxt;
  logic [2:0]      step_r, step_nxt;
  logic            erase_r, erase_nxt;
  logic            wchk_r, wchk_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0]      data_r, data_nxt;
  logic [7:0]      rd1_r, rd1_nxt;
  logic [7:0]      rd_r, rd_nxt;
  logic            busy_r, busy_nxt;
  logic            done_r, done_nxt;
  logic            fail_r, fail_nxt;
  logic            wlate_r, wlate_nxt;
  logic            wopen_r, wopen_nxt;
  logic            avs_wait_r, avs_wait_nxt;
  logic [31:0]     avs_rd_r, avs_rd_nxt;
  logic            go;
  logic [2:0]      n_steps;
  logic [ADDR_W-1:0] cmd_addr;
  logic [7:0]      cmd_data;
  logic            tog1_still, poll_ok;

  assign go      = i_avs_write && !avs_wait_r && (i_avs_address == fwsf_pkg::REG_CTRL)
                   && i_avs_writedata[fwsf_pkg::CTRL_GO] && (state_r == S_IDLE);
  // status only valid once the last write pulse has risen
  assign n_steps = erase_r ? 3'd6 : 3'd4;

  // standard unlock sequences; last cycle carries target address with program data or the erase command 30h
  always_comb begin
    cmd_addr = ADDR_W'(20'h00555);
    cmd_data = 8'haa;
    unique case (step_r)
      3'd0: begin cmd_addr = ADDR_W'(20'h00555); cmd_data = 8'haa; end
      3'd1: begin cmd_addr = ADDR_W'(20'h002aa); cmd_data = 8'h55; end
      3'd2: begin cmd_addr = ADDR_W'(20'h00555); cmd_data = erase_r ? 8'h80 : 8'ha0; end
      3'd3: begin
        cmd_addr = erase_r ? ADDR_W'(20'h00555) : addr_r;
        cmd_data = erase_r ? 8'haa : data_r;
      end
      3'd4: begin cmd_addr = ADDR_W'(20'h002aa); cmd_data = 8'h55; end
      default: begin cmd_addr = addr_r; cmd_data = 8'h30; end
    endcase
    if (state_r == S_RST) begin
      cmd_addr = addr_r;
      cmd_data = 8'hf0;
    end
  end

  // first toggle bit steady across two reads means the algorithm ended
  assign tog1_still = (rd1_r[fwsf_pkg::TOG1_BIT] == rd_r[fwsf_pkg::TOG1_BIT]);
  // poll bit equal to the same bit of programmed data, or erase done reads one
  assign poll_ok = erase_r ? rd_r[fwsf_pkg::POLL_BIT]
                           : (rd_r[fwsf_pkg::POLL_BIT] == data_r[fwsf_pkg::POLL_BIT]);

  always_comb begin
    state_nxt    = state_r;
    step_nxt     = step_r;
    erase_nxt    = erase_r;
    wchk_nxt     = wchk_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    rd1_nxt      = rd1_r;
    rd_nxt       = rd_r;
    busy_nxt     = busy_r;
    done_nxt     = done_r;
    fail_nxt     = fail_r;
    wlate_nxt    = wlate_r;
    wopen_nxt    = wopen_r;
    st_start     = 1'b0;
    st_write     = 1'b0;
    // idle high: one wait cycle per request, so read data stands when taken
    avs_wait_nxt = !((i_avs_read || i_avs_write) && avs_wait_r);
    avs_rd_nxt   = avs_rd_r;
    if (i_avs_write && !avs_wait_r) begin
      unique case (i_avs_address)
        fwsf_pkg::REG_ADDR: if (state_r == S_IDLE) addr_nxt = i_avs_writedata[ADDR_W-1:0];
        fwsf_pkg::REG_DATA: if (state_r == S_IDLE) data_nxt = i_avs_writedata[7:0];
        default: ;
      endcase
    end
    if (i_avs_read && avs_wait_r) begin
      unique case (i_avs_address)
        fwsf_pkg::REG_STATUS: avs_rd_nxt = {27'h0, wopen_r, wlate_r, fail_r, done_r, busy_r};
        fwsf_pkg::REG_DATA:   avs_rd_nxt = {24'h0, rd_r};
        fwsf_pkg::REG_ADDR:   avs_rd_nxt = 32'(addr_r);
        default:              avs_rd_nxt = fwsf_pkg::RESET_VAL;
      endcase
    end
    unique case (state_r)
      S_IDLE: if (go) begin
        erase_nxt = i_avs_writedata[fwsf_pkg::CTRL_ERASE];
        wchk_nxt  = i_avs_writedata[fwsf_pkg::CTRL_WIN_CHK];
        step_nxt  = 3'd0;
        busy_nxt  = 1'b1;
        done_nxt  = 1'b0;
        fail_nxt  = 1'b0;
        wlate_nxt = 1'b0;
        state_nxt = S_CMD;
        st_start  = 1'b1;
        st_write  = 1'b1;
      end
      S_CMD: if (st_done) begin
        if (step_r == n_steps - 3'd1) begin
          state_nxt = S_RD1;
          st_start  = 1'b1;
        end else begin
          step_nxt = step_r + 3'd1;
          st_start = 1'b1;
          st_write = 1'b1;
        end
      end
      S_RD1: if (smp_d2_r) begin
        rd1_nxt = dq_s2_r;
        // window bit seen after an extra sector erase: may be refused
        if (erase_r && wchk_r) wlate_nxt = dq_s2_r[fwsf_pkg::WIN_BIT];
        wopen_nxt = !dq_s2_r[fwsf_pkg::WIN_BIT];
      end else if (st_done) begin
        state_nxt = S_RD2;
        st_start  = 1'b1;
      end
      S_RD2: if (smp_d2_r) begin
        rd_nxt = dq_s2_r;
      end else if (st_done) begin
        state_nxt = S_CHECK;
      end
      S_CHECK: begin
        if (tog1_still && poll_ok) begin
          // protected targets end quietly too if the unchanged array byte passes poll_ok; a re-read yields clean data
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = S_IDLE;
        end else if (rd_r[fwsf_pkg::TOUT_BIT] && rd1_r[fwsf_pkg::TOUT_BIT]) begin
          // second look already taken after the timeout bit rose
          fail_nxt  = 1'b1;
          state_nxt = S_RST;
          st_start  = 1'b1;
          st_write  = 1'b1;
        end else begin
          // one new read, last second read becomes the first; strobes rise between reads so toggle bits advance
          rd1_nxt   = rd_r;
          state_nxt = S_RD2;
          st_start  = 1'b1;
        end
      end
      S_RST: if (st_done) begin
        busy_nxt  = 1'b0;
        done_nxt  = 1'b1;
        state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r    <= S_IDLE;
      step_r     <= 3'd0;
      erase_r    <= 1'b0;
      wchk_r     <= 1'b0;
      addr_r     <= '0;
      data_r     <= 8'h00;
      rd1_r      <= 8'h00;
      rd_r       <= 8'h00;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      fail_r     <= 1'b0;
      wlate_r    <= 1'b0;
      wopen_r    <= 1'b0;
      avs_wait_r <= 1'b1;
      avs_rd_r   <= 32'h0000_0000;
      o_fl_addr  <= '0;
      o_fl_dq    <= 8'h00;
      o_fl_dq_oe <= 1'b0;
      o_fl_ce_n  <= 1'b1;
      o_fl_oe_n  <= 1'b1;
      o_fl_we_n  <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      step_r     <= step_nxt;
      erase_r    <= erase_nxt;
      wchk_r     <= wchk_nxt;
      addr_r     <= addr_nxt;
      data_r     <= data_nxt;
      rd1_r      <= rd1_nxt;
      rd_r       <= rd_nxt;
      busy_r     <= busy_nxt;
      done_r     <= done_nxt;
      fail_r     <= fail_nxt;
      wlate_r    <= wlate_nxt;
      wopen_r    <= wopen_nxt;
      avs_wait_r <= avs_wait_nxt;
      avs_rd_r   <= avs_rd_nxt;
      // polling reads go to the target address: the programmed byte, or inside the erasing sector
      o_fl_addr  <= (state_r == S_CMD || state_r == S_RST) ? cmd_addr : addr_r;
      o_fl_dq    <= cmd_data;
      o_fl_dq_oe <= (state_r == S_CMD || state_r == S_RST);
      o_fl_ce_n  <= ce_n_w;
      o_fl_oe_n  <= oe_n_w;
      o_fl_we_n  <= we_n_w;
    end
  end

  assign o_avs_readdata    = avs_rd_r;
  assign o_avs_waitrequest = avs_wait_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  done_stable_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == S_CHECK && tog1_still && poll_ok) |=> (done_r && !busy_r))
    else $error("completion not reported after steady toggle bit");
  fail_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == S_CHECK && !(tog1_still && poll_ok) && rd_r[5] && rd1_r[5])
    |=> (fail_r && state_r == S_RST))
    else $error("timeout failure not followed by reset command");
  cmd_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == S_CMD && !erase_r && st_done) |-> (step_r <= 3'd3))
    else $error("program sequence longer than four writes");
  erase_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == S_CMD && erase_r && st_done && step_r == 3'd5) |=> (state_r == S_RD1))
    else $error("erase sequence did not end at sixth write");
  no_drive_rd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_fl_oe_n |-> !o_fl_dq_oe)
    else $error("data driven during read");
endmodule : fwsf_ctrl

/* File: rtl/fwsf_pkg.sv */
package fwsf_pkg;
  // ****************************************************************
  // bus decode, word index times four
  // ****************************************************************
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_ADDR      = 4'h4;
  localparam logic [3:0]  REG_DATA      = 4'h8;
  localparam logic [3:0]  REG_STATUS    = 4'hc;
  localparam logic [3:0]  REG_RDATA     = 4'h0;
  // ctrl fields
  localparam int          CTRL_GO       = 0;
  localparam int          CTRL_ERASE    = 1;
  localparam int          CTRL_WIN_CHK  = 2;
  // status fields
  localparam int          ST_BUSY       = 0;
  localparam int          ST_DONE       = 1;
  localparam int          ST_FAIL       = 2;
  localparam int          ST_WIN_LATE   = 3;
  localparam int          ST_WIN_OPEN   = 4;
  // flash data bit positions
  localparam int          POLL_BIT      = 7;
  localparam int          TOG1_BIT      = 6;
  localparam int          TOUT_BIT      = 5;
  localparam int          WIN_BIT       = 3;
  localparam int          TOG2_BIT      = 2;
  // strobe timing
  localparam int          CLK_NS        = 8;
  localparam int          T_STROBE_NS   = 70;
  localparam int          T_HIGH_NS     = 30;
  localparam int          STROBE_CYC    = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          HIGH_CYC      = (T_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] RESET_VAL     = 32'h0000_0000;
endpackage : fwsf_pkg

/* File: rtl/fwsf_strobe.sv */
`timescale 1ns/1ps
// one flash bus cycle: hold strobes low for a count, then high for a count
module fwsf_strobe #(
  parameter int LOW_CYC  = 9,
  parameter int HIGH_CYC = 4
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // request
  input  wire logic        i_start,
  input  wire logic        i_write,
  // pin side
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic             o_sample,
  output logic             o_done
);
  logic [7:0] cnt_r, cnt_nxt;
  logic       act_r, act_nxt;
  logic       wr_r, wr_nxt;
  logic       ce_n_nxt, oe_n_nxt, we_n_nxt, sample_nxt, done_nxt;

  always_comb begin
    cnt_nxt    = cnt_r;
    act_nxt    = act_r;
    wr_nxt     = wr_r;
    ce_n_nxt   = 1'b1;
    oe_n_nxt   = 1'b1;
    we_n_nxt   = 1'b1;
    sample_nxt = 1'b0;
    done_nxt   = 1'b0;
    if (!act_r) begin
      if (i_start) begin
        act_nxt  = 1'b1;
        wr_nxt   = i_write;
        cnt_nxt  = 8'h00;
        ce_n_nxt = 1'b0;
        oe_n_nxt = i_write;
        we_n_nxt = !i_write;
      end
    end else begin
      cnt_nxt = cnt_r + 8'h01;
      if (cnt_r < 8'(LOW_CYC - 1)) begin
        ce_n_nxt = 1'b0;
        oe_n_nxt = wr_r;
        we_n_nxt = !wr_r;
      end
      // strobes rise: read data is taken on the rising edge of oe
      if (cnt_r == 8'(LOW_CYC - 1)) begin
        sample_nxt = !wr_r;
      end
      // keep ce and oe high between reads so toggle bits advance
      if (cnt_r == 8'(LOW_CYC + HIGH_CYC - 1)) begin
        act_nxt  = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r    <= 8'h00;
      act_r    <= 1'b0;
      wr_r     <= 1'b0;
      o_ce_n   <= 1'b1;
      o_oe_n   <= 1'b1;
      o_we_n   <= 1'b1;
      o_sample <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      act_r    <= act_nxt;
      wr_r     <= wr_nxt;
      o_ce_n   <= ce_n_nxt;
      o_oe_n   <= oe_n_nxt;
      o_we_n   <= we_n_nxt;
      o_sample <= sample_nxt;
      o_done   <= done_nxt;
    end
  end

  write_hi_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(!o_we_n && !o_oe_n))
    else $error("write and read strobes low together");
endmodule : fwsf_strobe

/* File: verification/fwsf_flash_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// behavioural flash device: status flags while an algorithm runs
// ****************************************************************
module fwsf_flash_model #(
  parameter int AW = 20
) (
  // flash pins
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_dq,
  input  wire logic          i_ce_n,
  input  wire logic          i_oe_n,
  input  wire logic          i_we_n,
  output logic [7:0]         o_dq
);
  logic [7:0]    mem [int];
  int            seq_r = 0, mode_r = 0, busy_r = 0, win_r = 0, lock_r = 0;
  int            n_wr = 0, n_rst = 0;
  int            prog_reads = 4, erase_reads = 6, win_reads = 2;
  logic          tog1_r = 1'b0, tog2_r = 1'b0, wsel = 1'b0, rsel = 1'b0;
  logic [7:0]    pd_r, wd, out_r = 8'h00;
  logic [AW-1:0] pa_r, wa;

  function automatic logic [7:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : peek

  // top sector is the protected one
  function automatic logic prot(input logic [AW-1:0] a);
    return a[AW-1 -: 4] == 4'hf;
  endfunction : prot

  // ****************************************************************
  // command writes, taken when the write strobe rises
  // ****************************************************************
  always @(i_addr, i_dq, i_ce_n, i_we_n, i_oe_n) begin
    if (!i_ce_n && !i_we_n && i_oe_n) begin
      wsel = 1'b1;
      wa = i_addr;
      wd = i_dq;
    end
    if (!i_ce_n && !i_oe_n) begin
      rsel = 1'b1;
      if (mode_r == 1)
        out_r = {~pd_r[7], tog1_r, lock_r > 2, 2'b00, 1'b1, 2'h0};
      else if (mode_r == 2)
        out_r = {1'b0, tog1_r, 2'b00, win_r == 0, tog2_r, 2'h0};
      else
        out_r = peek(int'(i_addr));
    end
  end

  always @(posedge i_we_n or posedge i_ce_n) begin
    if (wsel) begin
      wsel = 1'b0;
      n_wr++;
      if (wd == 8'hf0) begin
        mode_r = 0;
        seq_r = 0;
        n_rst++;
      end else if (mode_r == 0) begin
        case (seq_r)
          0, 3: seq_r = (wd == 8'haa) ? seq_r + 1 : 0;
          1, 4: seq_r = (wd == 8'h55) ? seq_r + 1 : 0;
          2: seq_r = (wd == 8'ha0) ? 10 : (wd == 8'h80) ? 3 : 0;
          10: begin
            pa_r = wa;
            pd_r = wd;
            mode_r = 1;
            seq_r = 0;
            busy_r = prot(wa) ? 2 : prog_reads;
            lock_r = (!prot(wa) && peek(int'(wa)) != 8'hff) ? 1 : 0;
          end
          5: begin
            if (wd == 8'h30) begin
              pa_r = wa;
              mode_r = 2;
              busy_r = erase_reads;
              win_r = win_reads;
              lock_r = 0;
            end
            seq_r = 0;
          end
          default: seq_r = 0;
        endcase
      end
    end
  end

  // ****************************************************************
  // a completed read advances the toggle bits and the algorithm
  // ****************************************************************
  always @(posedge i_oe_n or posedge i_ce_n) begin
    if (rsel) begin
      rsel = 1'b0;
      if (mode_r != 0) begin
        // no suspend modelled: first toggle bit flips whenever an algorithm is active, second only during erase
        tog1_r = ~tog1_r;
        if (mode_r == 2)
          tog2_r = ~tog2_r;
        if (win_r > 0)
          win_r--;
        if (lock_r > 0)
          lock_r++;
        else if (busy_r > 1)
          busy_r--;
        else begin
          if (mode_r == 1 && !prot(pa_r))
            mem[int'(pa_r)] = pd_r;
          if (mode_r == 2 && !prot(pa_r))
            foreach (mem[k])
              if (k[AW-1 -: 4] == pa_r[AW-1 -: 4])
                mem[k] = 8'hff;
          mode_r = 0;
        end
      end
    end
  end

  // undriven bus shows the inverse of the last value, no pull
  assign o_dq = (!i_ce_n && !i_oe_n) ? out_r : ~out_r;
endmodule : fwsf_flash_model

/* File: verification/test_flash_write_status_flags.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench: software orders over the register bus, device model below
// ****************************************************************
module test_flash_write_status_flags;
  logic        i_clk, i_rst_n;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [19:0] fl_addr, a;
  logic [19:0] pa [4];
  logic [7:0]  fl_dq_o, dev_dq, dq_wire, d;
  logic        fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  int          err_total, samples_checked, cyc, nwr0, nrst0;
  int          ref_mem [int];

  assign dq_wire = fl_dq_oe ? fl_dq_o : dev_dq;

  fwsf_ctrl #(.ADDR_W(20)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .o_fl_addr(fl_addr), .i_fl_dq(dq_wire), .o_fl_dq(fl_dq_o), .o_fl_dq_oe(fl_dq_oe),
    .o_fl_ce_n(fl_ce_n), .o_fl_oe_n(fl_oe_n), .o_fl_we_n(fl_we_n));

  fwsf_flash_model #(.AW(20)) i_flash (
    .i_addr(fl_addr), .i_dq(dq_wire), .i_ce_n(fl_ce_n), .i_oe_n(fl_oe_n),
    .i_we_n(fl_we_n), .o_dq(dev_dq));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // hang guard, far above the longest run
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  function automatic logic [7:0] ref_rd(input int k);
    return ref_mem.exists(k) ? 8'(ref_mem[k]) : 8'hff;
  endfunction : ref_rd

  task automatic bus_wr(input logic [3:0] ad, input logic [31:0] dt);
    avs_address <= ad;
    avs_writedata <= dt;
    avs_write <= 1'b1;
    do @(posedge i_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge i_clk);
  endtask : bus_wr

  // read data taken at the same edge that sees waitrequest low
  task automatic bus_rd(input logic [3:0] ad, output logic [31:0] dt);
    avs_address <= ad;
    avs_read <= 1'b1;
    do @(posedge i_clk); while (avs_waitrequest !== 1'b0);
    dt = avs_readdata;
    avs_read <= 1'b0;
    @(posedge i_clk);
  endtask : bus_rd

  task automatic run_op(input logic [19:0] ad, input logic [7:0] dt, input logic [2:0] ctl,
                        input logic [4:0] exp_st, input logic [4:0] msk, input int exp_wr);
    int n;
    nwr0 = i_flash.n_wr;
    nrst0 = i_flash.n_rst;
    bus_wr(fwsf_pkg::REG_ADDR, {12'h000, ad});
    bus_wr(fwsf_pkg::REG_DATA, {24'h000000, dt});
    bus_wr(fwsf_pkg::REG_CTRL, {29'h0, ctl});
    n = 0;
    do begin
      bus_rd(fwsf_pkg::REG_STATUS, rd);
      n++;
    end while (rd[fwsf_pkg::ST_BUSY] !== 1'b0 && n < 3000);
    check({27'h0, rd[4:0] & msk}, {27'h0, exp_st & msk}, "status");
    check(32'(i_flash.n_wr - nwr0), 32'(exp_wr), "write pulses");
  endtask : run_op

  initial begin
    i_rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    void'($urandom(29));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    check({28'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 32'he, "idle pins");
    // ****************************************************************
    // blank programs, short and long busy runs
    // ****************************************************************
    for (int k = 0; k < 4; k++) begin
      pa[k] = {4'(k), 16'($urandom)};
      // never all ones, so the later overwrite of pa[3] is sure to lock
      d = 8'($urandom) & 8'hfe;
      i_flash.prog_reads = 1 + 3 * k;
      run_op(pa[k], d, 3'b001, 5'b00010, 5'b00111, 4);
      ref_mem[int'(pa[k])] = d;
      bus_rd(fwsf_pkg::REG_DATA, rd);
      check(rd, {24'h0, d}, "polled byte");
      check({24'h0, i_flash.peek(int'(pa[k]))}, {24'h0, ref_rd(int'(pa[k]))}, "array");
    end
    $display("test blank program done");
    // non-blank target locks up and needs the reset command
    run_op(pa[3], ~ref_rd(int'(pa[3])), 3'b001, 5'b00100, 5'b00101, 5);
    check(32'(i_flash.n_rst - nrst0), 32'h1, "reset command");
    check({24'h0, i_flash.peek(int'(pa[3]))}, {24'h0, ref_rd(int'(pa[3]))}, "locked");
    $display("test locked program done");
    // protected sector: short busy run, nothing stored
    a = {4'hf, 16'($urandom)};
    run_op(a, 8'($urandom) | 8'h80, 3'b001, 5'b00010, 5'b00111, 4);
    check({24'h0, i_flash.peek(int'(a))}, {24'h0, ref_rd(int'(a))}, "protected");
    $display("test protected program done");
    // ****************************************************************
    // sector erase with window check, open then already closed, then a protected sector without window check
    // ****************************************************************
    for (int k = 0; k < 2; k++) begin
      i_flash.win_reads = 3 - 3 * k;
      i_flash.erase_reads = 8;
      run_op(pa[k], 8'h00, 3'b111, k ? 5'b01010 : 5'b10010, 5'b11111, 6);
      foreach (ref_mem[j])
        if (j[19:16] == k)
          ref_mem[j] = 8'hff;
      check({24'h0, i_flash.peek(int'(pa[k]))}, {24'h0, ref_rd(int'(pa[k]))}, "erased");
    end
    run_op({4'hf, 16'h0}, 8'h00, 3'b011, 5'b00010, 5'b00111, 6);
    $display("test erase done");
    // ****************************************************************
    // write-only and unmapped places read as zero
    // ****************************************************************
    bus_rd(4'h1, rd);
    check(rd, 32'h0, "unmapped");
    bus_rd(fwsf_pkg::REG_CTRL, rd);
    check(rd, 32'h0, "ctrl read");
    $display("test register map done");
    stop_test();
  end
endmodule : test_flash_write_status_flags
